// ---- ios_map.svh ----
// constants of the internal oscillator block: register offsets, field positions, reset values, timing
// assumes the includer works on a 250 MHz system clock and an 8-bit register port
`ifndef IOS_MAP_SVH
`define IOS_MAP_SVH

// register offsets
`define IOS_OFS_CONTROL   8'h8F
`define IOS_OFS_TRIM      8'h90

// osc_control_register fields
`define IOS_SEL_MSB       6
`define IOS_SEL_LSB       4
`define IOS_STABLE_BIT    2
`define IOS_SEL_RESET     3'h0
`define IOS_TRIM_RESET    6'h00
`define IOS_SEL_SLOW      3'h0
`define IOS_SEL_FAST      3'h7

// osc_mode_config_bits codes for the two internal modes
`define IOS_MODE_CLKOUT   3'h4
`define IOS_MODE_ALL_IO   3'h5

// clock rate and settling time
`define IOS_CLK_KHZ       250000
`define IOS_SETTLE_MS     4
`define IOS_SETTLE_CYC    (`IOS_SETTLE_MS * `IOS_CLK_KHZ)

// phase increments: 8 MHz and 31.25 kHz out of 250 MHz on a 32-bit accumulator
`define IOS_FAST_INC      32'h083126E9
`define IOS_SLOW_INC      32'h00083127
// one trim step is 1/256 of the nominal rate, 32 steps give 12.5 percent
`define IOS_TRIM_SHIFT    8

// switch: falling edges of the new source before it is connected
`define IOS_NEW_EDGES     4'h8

`endif

// ---- ios_pkg.sv ----
// types shared by the internal oscillator block
// assumes ios_map.svh supplies the numeric constants
package ios_pkg;

  typedef logic [2:0] ios_sel_t;   // frequency select code
  typedef logic [2:0] ios_mode_t;  // oscillator mode configuration
  typedef logic [5:0] ios_trim_t;  // signed trim value

  // glitch-free switch states
  typedef enum logic [2:0] {
    IOS_RUN      = 3'b001,
    IOS_WAIT_OLD = 3'b010,
    IOS_WAIT_NEW = 3'b100
  } ios_sw_state_t;

endpackage

// ---- ios_osc_if.sv ----
// carrier between the oscillator top and one trimmed source
// assumes one clock domain, CLK_SYS
`timescale 1ns/1ps
interface ios_osc_if;
  import ios_pkg::*;
  logic      run;     // source enabled
  ios_trim_t trim;    // trim value applied to the source
  logic      level;   // square-wave output level
  modport src (input run, input trim, output level);
  modport ctl (output run, output trim, input level);
endinterface

// ---- ios_nco.sv ----
// trimmed oscillator source modelled as a phase accumulator on the system clock
// assumes CLK_SYS is far faster than the produced rate
`timescale 1ns/1ps
`include "ios_map.svh"
module ios_nco #(
  parameter logic [31:0] BASE_INC  = `IOS_FAST_INC,
  parameter bit          TRIM_WRAP = 1'b0
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // source carrier
  ios_osc_if.src   osc
);
  import ios_pkg::*;

  logic [31:0]        acc_q;     // phase accumulator
  logic [31:0]        inc_q;     // increment in use
  logic signed [39:0] scaled;    // nominal times trim
  logic [31:0]        inc_d;     // increment requested by trim
  logic [32:0]        sum;       // accumulator plus carry

  // a zero increment would leave the source stuck, so it is refused at elaboration
  if (BASE_INC == 32'h0) begin : g_bad_inc
    $error("ios_nco: zero increment");
  end

  // linear trim: each step moves the rate by the same fraction
  always_comb begin
    scaled = $signed({8'h00, BASE_INC}) * $signed(osc.trim);
    inc_d  = BASE_INC + 32'(scaled >>> `IOS_TRIM_SHIFT);
  end

  assign sum = {1'b0, acc_q} + {1'b0, inc_q};

  // accumulator; a stopped source sits low and restarts from phase zero
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      acc_q <= 32'h0;
    end else if (!osc.run) begin
      acc_q <= 32'h0;
    end else begin
      acc_q <= sum[31:0];
    end
  end

  // new trim: the slow source takes it at its next wrap, well inside 8 of its cycles,
  // the fast one takes it at once, well inside 1 ms
  // no done flag is kept, the core never stalls on it
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      inc_q <= BASE_INC;
    end else if (!TRIM_WRAP || sum[32] || !osc.run) begin
      inc_q <= inc_d;
    end
  end

  assign osc.level = acc_q[31];
endmodule

// ---- ios_top.sv ----
// internal oscillator block: fast and slow trimmed sources, postscaler, glitch-free switch,
// stability flag, register port and the two oscillator pins in the internal modes
// assumes inputs synchronous to CLK_SYS and a register master that never waits
`timescale 1ns/1ps
`include "ios_map.svh"
module ios_top #(
  parameter int unsigned SETTLE_CYCLES = `IOS_SETTLE_CYC
) (
  // clock and reset
  input  wire logic             CLK_SYS,
  input  wire logic             RST,
  // register port
  input  wire logic [7:0]       ADDR,
  input  wire logic [7:0]       WDATA,
  input  wire logic             WR,
  input  wire logic             RD,
  output logic      [7:0]       RDATA,
  // configuration and enables
  input  wire ios_pkg::ios_mode_t OSC_MODE,
  input  wire logic             PWRT_EN,
  input  wire logic             WDT_EN,
  input  wire logic             EXT_CLK,
  // clocks out
  output logic                  SYS_CLK,
  output logic                  SLOW_CLK,
  output logic                  INT_ACTIVE,
  // osc_input_pin
  input  wire logic             OSC_IN_PIN_I,
  output logic                  OSC_IN_PIN_O,
  output logic                  OSC_IN_PIN_OE,
  // osc_output_pin
  input  wire logic             OSC_OUT_PIN_I,
  output logic                  OSC_OUT_PIN_O,
  output logic                  OSC_OUT_PIN_OE,
  // port a bits 7 and 6 from and to the port logic
  input  wire logic             PORT_A_BIT7_O,
  input  wire logic             PORT_A_BIT7_OE,
  output logic                  PORT_A_BIT7_I,
  input  wire logic             PORT_A_BIT6_O,
  input  wire logic             PORT_A_BIT6_OE,
  output logic                  PORT_A_BIT6_I
);
  import ios_pkg::*;

  // the settling counter is 24 bits wide; zero would never set the flag and a larger
  // count would be cut short by the load, so both are refused at elaboration
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 32'h00FFFFFF) begin : g_bad_settle
    $error("ios_top: SETTLE_CYCLES out of range");
  end

  // register state
  ios_sel_t      freq_sel_q;     // freq_select_field
  ios_trim_t     trim_q;         // trim_value_field
  logic          stable_q;       // fast_freq_stable_flag
  logic [23:0]   settle_q;       // settling countdown, zero when idle
  logic [7:0]    rdata_q;        // read answer
  logic          wr_ctl;         // write to control register
  logic          wr_trim;        // write to trim register
  logic          leave_slow;     // write that moves away from the slow code
  logic          settle_done;    // countdown expires this cycle

  // sources
  ios_osc_if     fast_if ();     // fast_internal_source carrier
  ios_osc_if     slow_if ();     // slow_internal_source carrier
  logic [5:0]    post_q;         // postscaler binary counter
  logic          fast_prev_q;    // fast level one cycle back
  logic [7:0]    lv;             // level of each selectable output
  logic [7:0]    lv_q;           // the same one cycle back
  logic [7:0]    fall;           // falling edge per output

  // switch
  ios_sw_state_t sw_q;           // switch state
  ios_sel_t      cur_q;          // code now driving the clock
  ios_sel_t      tgt_q;          // code being connected
  logic [3:0]    edges_q;        // falling edges of the target seen
  logic          int_clk_q;      // internal clock output

  // outputs
  logic          internal_mode;  // one of the two internal modes
  logic          sys_clk_q;      // system clock as driven out
  logic [1:0]    quarter_q;      // divide-by-four of system clock
  logic          sys_prev_q;     // system clock one cycle back
  logic          pa7_q;          // sampled input pin
  logic          pa6_q;          // sampled output pin

  // decode of the register port
  assign wr_ctl      = WR && (ADDR == `IOS_OFS_CONTROL);
  assign wr_trim     = WR && (ADDR == `IOS_OFS_TRIM);
  assign leave_slow  = wr_ctl && (freq_sel_q == `IOS_SEL_SLOW)
                       && (WDATA[`IOS_SEL_MSB:`IOS_SEL_LSB] != `IOS_SEL_SLOW);
  assign settle_done = (settle_q == 24'h000001);

  // select field: taken on any write, whatever source is running
  // the requested multiplexer input follows the field at once
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      freq_sel_q <= `IOS_SEL_RESET;
    end else if (wr_ctl) begin
      freq_sel_q <= WDATA[`IOS_SEL_MSB:`IOS_SEL_LSB];
    end
  end

  // trim field
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      trim_q <= `IOS_TRIM_RESET;
    end else if (wr_trim) begin
      trim_q <= WDATA[5:0];
    end
  end

  // settling countdown on the system clock, a source that never changes rate
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      settle_q <= 24'h000000;
    end else if (leave_slow) begin
      settle_q <= 24'(SETTLE_CYCLES);
    end else if (settle_q != 24'h000000) begin
      settle_q <= settle_q - 24'h000001;
    end
  end

  // stability flag: expiry sets it, leaving the slow code clears it;
  // a set and a clear in one cycle keep the set so the event is not lost
  // a switch between two fast codes does not touch it
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      stable_q <= 1'b0;
    end else if (settle_done) begin
      stable_q <= 1'b1;
    end else if (leave_slow) begin
      stable_q <= 1'b0;
    end
  end

  // read answer stands for one cycle after the strobe; unmapped reads give zero
  // the master never waits, so the answer is a plain register with no ready handshake
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rdata_q <= 8'h00;
    end else if (RD && ADDR == `IOS_OFS_CONTROL) begin
      rdata_q <= {1'b0, freq_sel_q, 1'b0, stable_q, 2'b00};
    end else if (RD && ADDR == `IOS_OFS_TRIM) begin
      rdata_q <= {2'b00, trim_q};
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign RDATA = rdata_q;

  // fast source always runs so the postscaler rates exist at any moment
  assign fast_if.run  = 1'b1;
  assign fast_if.trim = trim_q;

  // an idle slow source is stopped to save power and restarts from phase zero
  // slow source runs when selected, being left, or wanted by timer or watchdog
  assign slow_if.run  = (freq_sel_q == `IOS_SEL_SLOW) || (cur_q == `IOS_SEL_SLOW)
                        || (tgt_q == `IOS_SEL_SLOW) || PWRT_EN || WDT_EN;
  assign slow_if.trim = trim_q;                            // trim shared by both sources

  ios_nco #(
    .BASE_INC  (`IOS_FAST_INC),
    .TRIM_WRAP (1'b0)
  ) u_fast (
    .CLK_SYS (CLK_SYS),
    .RST     (RST),
    .osc     (fast_if)
  );

  ios_nco #(
    .BASE_INC  (`IOS_SLOW_INC),
    .TRIM_WRAP (1'b1)
  ) u_slow (
    .CLK_SYS (CLK_SYS),
    .RST     (RST),
    .osc     (slow_if)
  );

  // postscaler: binary count of fast rising edges, bit k divides by 2^(k+1)
  // it is clocked off the fast level, so every derived rate follows the fast trim
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      fast_prev_q <= 1'b0;
      post_q      <= 6'h00;
    end else begin
      fast_prev_q <= fast_if.level;
      if (fast_if.level && !fast_prev_q) begin
        post_q <= post_q + 6'h01;
      end
    end
  end

  // selectable outputs by code: 0 slow, 1..6 postscaler 64 down to 2, 7 fast
  assign lv[0] = slow_if.level;
  assign lv[7] = fast_if.level;
  genvar gi;
  generate
    for (gi = 1; gi < 7; gi++) begin : g_post
      assign lv[gi] = post_q[6 - gi];
    end
  endgenerate

  // falling edges of every output, for the switch sequence
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      lv_q <= 8'h00;
    end else begin
      lv_q <= lv;
    end
  end

  assign fall = lv_q & ~lv;

  // glitch-free switch: the old clock is parked low at its falling edge, the new one
  // is connected only after eight of its falling edges, so no short pulse escapes
  // limitation: a code rewritten faster than eight new falls keeps the output parked
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sw_q    <= IOS_RUN;
      cur_q   <= `IOS_SEL_RESET;
      tgt_q   <= `IOS_SEL_RESET;
      edges_q <= 4'h0;
    end else begin
      case (sw_q)
        IOS_RUN: begin
          // a new request starts the sequence
          if (freq_sel_q != cur_q) begin
            sw_q <= IOS_WAIT_OLD;
          end
        end
        IOS_WAIT_OLD: begin
          // wait on the falling edge of the running clock
          if (fall[cur_q]) begin
            sw_q    <= IOS_WAIT_NEW;
            tgt_q   <= freq_sel_q;
            edges_q <= 4'h0;
          end
        end
        IOS_WAIT_NEW: begin
          if (freq_sel_q != tgt_q) begin
            // request moved again: count afresh for the latest code
            tgt_q   <= freq_sel_q;
            edges_q <= 4'h0;
          end else if (fall[tgt_q]) begin
            if (edges_q == `IOS_NEW_EDGES - 4'h1) begin
              sw_q  <= IOS_RUN;
              cur_q <= tgt_q;
            end
            edges_q <= edges_q + 4'h1;
          end
        end
        default: begin
          sw_q <= IOS_RUN;
        end
      endcase
    end
  end

  // internal clock level: the running source, or held low while waiting for the new one
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      int_clk_q <= 1'b0;
    end else if (sw_q == IOS_WAIT_NEW || (sw_q == IOS_WAIT_OLD && fall[cur_q])) begin
      int_clk_q <= 1'b0;
    end else begin
      int_clk_q <= lv[cur_q];
    end
  end

  // the internal block owns the system clock only in the two internal modes
  // the level is registered: one cycle of lag, but no glitch from the mode mux
  assign internal_mode = (OSC_MODE == `IOS_MODE_CLKOUT) || (OSC_MODE == `IOS_MODE_ALL_IO);

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sys_clk_q <= 1'b0;
    end else if (internal_mode) begin
      sys_clk_q <= int_clk_q;
    end else begin
      sys_clk_q <= EXT_CLK;
    end
  end

  // quarter of the system clock, stepped on its falling edges
  // it counts in every mode, so the first quarter period after a mode change may be short
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sys_prev_q <= 1'b0;
      quarter_q  <= 2'b00;
    end else begin
      sys_prev_q <= sys_clk_q;
      if (sys_prev_q && !sys_clk_q) begin
        quarter_q <= quarter_q + 2'b01;
      end
    end
  end

  // pin inputs handed to the port logic, registered so they are clean data
  // this costs one cycle of latency on port reads of bits 7 and 6
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pa7_q <= 1'b0;
      pa6_q <= 1'b0;
    end else begin
      pa7_q <= OSC_IN_PIN_I;
      pa6_q <= OSC_OUT_PIN_I;
    end
  end

  assign PORT_A_BIT7_I = pa7_q;
  assign PORT_A_BIT6_I = pa6_q;

  // input pin is port bit 7 in both internal modes
  // outside them the external oscillator owns the pin, so it stays undriven here
  assign OSC_IN_PIN_O  = internal_mode ? PORT_A_BIT7_O : 1'b0;
  assign OSC_IN_PIN_OE = internal_mode && PORT_A_BIT7_OE;

  // output pin: quarter clock in clock-out mode port bit 6 in all-io mode
  assign OSC_OUT_PIN_O  = (OSC_MODE == `IOS_MODE_CLKOUT) ? quarter_q[1]
                        : (OSC_MODE == `IOS_MODE_ALL_IO) ? PORT_A_BIT6_O : 1'b0;
  assign OSC_OUT_PIN_OE = (OSC_MODE == `IOS_MODE_CLKOUT)
                        || ((OSC_MODE == `IOS_MODE_ALL_IO) && PORT_A_BIT6_OE);

  // software waits on the flag before trusting the rate
  assign SYS_CLK    = sys_clk_q;
  assign SLOW_CLK   = slow_if.level;
  assign INT_ACTIVE = internal_mode;
endmodule

// ---- ios_top_properties.sv ----
// checker for the oscillator block: register reads, flag, mode pins
// assumes it is bound to ios_top and sees its ports only
`timescale 1ns/1ps
module ios_top_properties #(
  parameter int unsigned SETTLE_CYCLES = 50
) (
  // clock and reset
  input wire logic       CLK_SYS,
  input wire logic       RST,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  // mode, clock and pins
  input wire ios_pkg::ios_mode_t OSC_MODE,
  input wire logic       SYS_CLK,
  input wire logic       INT_ACTIVE,
  input wire logic       OSC_IN_PIN_OE,
  input wire logic       OSC_OUT_PIN_O,
  input wire logic       OSC_OUT_PIN_OE,
  input wire logic       PORT_A_BIT7_OE,
  input wire logic       PORT_A_BIT6_OE
);
  import ios_pkg::*;
  logic [2:0]  sel_q;  // shadow of the select field
  logic [5:0]  trim_q; // shadow of the trim field
  int unsigned cnt_q;  // cycles in which the flag may not read set
  logic [7:0]  rcnt_q; // system clock rises since the last divided rise
  logic        seen_q; // a divided rise was seen in this mode

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // shadows follow writes; two cycles of margin cover the read latency
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sel_q  <= 3'h0;
      trim_q <= 6'h00;
      cnt_q  <= 0;
    end else begin
      if (WR && ADDR == 8'h90) trim_q <= WDATA[5:0];
      if (WR && ADDR == 8'h8F) sel_q <= WDATA[6:4];
      if (WR && ADDR == 8'h8F && sel_q == 3'h0 && WDATA[6:4] != 3'h0) cnt_q <= SETTLE_CYCLES - 2;
      else if (cnt_q != 0) cnt_q <= cnt_q - 1;
    end
  end

  // divided clock count restarts whenever clock-out mode is left
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST || OSC_MODE != 3'h4) begin
      rcnt_q <= 8'h00;
      seen_q <= 1'b0;
    end else if ($rose(OSC_OUT_PIN_O)) begin
      rcnt_q <= 8'h00;
      seen_q <= 1'b1;
    end else if ($rose(SYS_CLK)) begin
      rcnt_q <= rcnt_q + 8'h01;
    end
  end

  ctrl_unused_a:
    assert property (RD && ADDR == 8'h8F |=> {RDATA[7], RDATA[3], RDATA[1:0]} == 4'h0) else $error("control spare bits set");
  sel_readback_a:
    assert property (RD && ADDR == 8'h8F |=> RDATA[6:4] == sel_q) else $error("select field read wrong");
  trim_readback_a:
    assert property (RD && ADDR == 8'h90 |=> RDATA == {2'h0, trim_q}) else $error("trim read wrong");
  unmapped_zero_a:
    assert property (RD && ADDR != 8'h8F && ADDR != 8'h90 |=> RDATA == 8'h00) else $error("unmapped read not zero");
  early_stable_a:
    assert property (cnt_q != 0 |-> !RDATA[2]) else $error("flag set during settling");
  mode_active_a:
    assert property (INT_ACTIVE == (OSC_MODE == 3'h4 || OSC_MODE == 3'h5)) else $error("internal mode flag wrong");
  ext_pins_a:
    assert property (!INT_ACTIVE |-> !OSC_OUT_PIN_OE && !OSC_IN_PIN_OE) else $error("pin driven in other mode");
  clkout_pins_a:
    assert property (OSC_MODE == 3'h4 |-> OSC_OUT_PIN_OE && OSC_IN_PIN_OE == PORT_A_BIT7_OE) else $error("clock-out pins wrong");
  allio_pins_a:
    assert property (OSC_MODE == 3'h5 |-> OSC_OUT_PIN_OE == PORT_A_BIT6_OE && OSC_IN_PIN_OE == PORT_A_BIT7_OE)
      else $error("all-io pins wrong");
  quarter_div_a:
    assert property (seen_q && $rose(OSC_OUT_PIN_O) |-> rcnt_q == 8'h04) else $error("clock out not a quarter");

  cover property (cnt_q == SETTLE_CYCLES - 2);
  cover property (RDATA[2]);
  cover property (OSC_MODE == 3'h5 && INT_ACTIVE);
endmodule

bind ios_top ios_top_properties #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_props (
  .CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .OSC_MODE(OSC_MODE), .SYS_CLK(SYS_CLK), .INT_ACTIVE(INT_ACTIVE), .OSC_IN_PIN_OE(OSC_IN_PIN_OE),
  .OSC_OUT_PIN_O(OSC_OUT_PIN_O), .OSC_OUT_PIN_OE(OSC_OUT_PIN_OE), .PORT_A_BIT7_OE(PORT_A_BIT7_OE),
  .PORT_A_BIT6_OE(PORT_A_BIT6_OE));

// ---- ios_port_model.sv ----
// port logic and board model at the two oscillator pins
// assumes pin levels are resolved here from every party's enable
`timescale 1ns/1ps
module ios_port_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // pin drive from the block
  input wire logic in_pin_o,
  input wire logic in_pin_oe,
  input wire logic out_pin_o,
  input wire logic out_pin_oe,
  // resolved pin levels
  output logic     in_pin_i,
  output logic     out_pin_i,
  // port bit drive
  output logic     bit7_o,
  output logic     bit7_oe,
  output logic     bit6_o,
  output logic     bit6_oe
);
  logic [3:0] pat_q; // running pattern so every enable and level gets exercised

  // pattern steps each cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) pat_q <= 4'h0;
    else pat_q <= pat_q + 4'h1;
  end

  assign bit7_o  = pat_q[0];
  assign bit7_oe = pat_q[2];
  assign bit6_o  = ~pat_q[0];
  assign bit6_oe = pat_q[3];
  // an undriven pin floats, so it shows a changing level, never a held one
  assign in_pin_i  = in_pin_oe ? in_pin_o : ~pat_q[0];
  assign out_pin_i = out_pin_oe ? out_pin_o : pat_q[1];
endmodule

// ---- ios_top_test.sv ----
// self-checking bench of the oscillator block
// assumes a shortened settling count and the port model at the pins
`timescale 1ns/1ps
`define IOS_CHK(act, exp, msg) \
  begin \
    check_count++; \
    if ((act) !== (exp)) begin \
      fail_count++; \
      $display("MISMATCH %0t %s", $time, msg); \
    end \
  end
module ios_top_test;
  import ios_pkg::*;
  localparam int unsigned SETTLE = 50; // short settling keeps the run brief
  localparam int CEIL = 95000;         // run ceiling in cycles, above the ~84000 a clean run takes
  logic       CLK_SYS = 1'b0;
  logic       RST = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic       WR = 1'b0;
  logic       RD = 1'b0;
  ios_mode_t  OSC_MODE = 3'h4;
  logic       PWRT_EN = 1'b0;
  logic       WDT_EN = 1'b0;
  logic       EXT_CLK = 1'b0;
  logic [7:0] RDATA;
  logic       SYS_CLK, SLOW_CLK, INT_ACTIVE, IN_I, IN_O, IN_OE, OUT_I, OUT_O, OUT_OE;
  logic       B7_O, B7_OE, B7_I, B6_O, B6_OE, B6_I;
  int         fail_count = 0;
  int         check_count = 0;
  int         cyc = 0;

  ios_top #(.SETTLE_CYCLES(SETTLE)) dut (
    .CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .OSC_MODE(OSC_MODE), .PWRT_EN(PWRT_EN), .WDT_EN(WDT_EN), .EXT_CLK(EXT_CLK), .SYS_CLK(SYS_CLK),
    .SLOW_CLK(SLOW_CLK), .INT_ACTIVE(INT_ACTIVE), .OSC_IN_PIN_I(IN_I), .OSC_IN_PIN_O(IN_O),
    .OSC_IN_PIN_OE(IN_OE), .OSC_OUT_PIN_I(OUT_I), .OSC_OUT_PIN_O(OUT_O), .OSC_OUT_PIN_OE(OUT_OE),
    .PORT_A_BIT7_O(B7_O), .PORT_A_BIT7_OE(B7_OE), .PORT_A_BIT7_I(B7_I), .PORT_A_BIT6_O(B6_O),
    .PORT_A_BIT6_OE(B6_OE), .PORT_A_BIT6_I(B6_I));
  ios_port_model u_port (
    .clk_sys(CLK_SYS), .rst(RST), .in_pin_o(IN_O), .in_pin_oe(IN_OE), .out_pin_o(OUT_O),
    .out_pin_oe(OUT_OE), .in_pin_i(IN_I), .out_pin_i(OUT_I), .bit7_o(B7_O), .bit7_oe(B7_OE),
    .bit6_o(B6_O), .bit6_oe(B6_OE));

  // 250 MHz clock, and an outside clock for the non-internal modes
  always #2 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) EXT_CLK <= ~EXT_CLK;

  // cut a hang short
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc >= CEIL) begin
      fail_count++;
      $display("MISMATCH %0t run ceiling reached", $time);
      close_out();
    end
  end

  task close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // register write: one strobe cycle
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask

  // register read: data stand only in the cycle after the strobe
  task expect_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    // the answer still stands in the active region of the next edge
    @(posedge CLK_SYS);
    `IOS_CHK(RDATA, e, "register read")
  endtask

  // count rises of the system clock, or of the slow clock, over n cycles
  task rises(input int n, input bit slow, output int c);
    logic p;
    c = 0;
    p = slow ? SLOW_CLK : SYS_CLK;
    repeat (n) begin
      @(posedge CLK_SYS);
      if ((slow ? SLOW_CLK : SYS_CLK) === 1'b1 && p === 1'b0) c++;
      p = slow ? SLOW_CLK : SYS_CLK;
    end
  endtask

  // wait for the system clock to move to lvl, at most lim cycles
  task wait_sys(input logic lvl, input int lim, output int n);
    logic p;
    n = 0;
    p = SYS_CLK;
    while (n < lim) begin
      @(posedge CLK_SYS);
      n++;
      if (p === ~lvl && SYS_CLK === lvl) break;
      p = SYS_CLK;
    end
  endtask

  task t_modes;
    for (int m = 0; m < 8; m++) begin
      OSC_MODE <= 3'(m);
      repeat (4) @(posedge CLK_SYS);
      `IOS_CHK(INT_ACTIVE, logic'(m == 4 || m == 5), "internal mode flag")
    end
    OSC_MODE <= 3'h4;
  endtask

  // leave the slow source: flag clears, output parks low for eight new falls
  task t_leave_slow;
    int n;
    wr(8'h8F, 8'hFF);
    expect_rd(8'h8F, 8'h70);
    wait_sys(1'b0, 8200, n);
    `IOS_CHK(n < 8200, 1'b1, "old clock never fell")
    wait_sys(1'b1, 400, n);
    `IOS_CHK(n >= 210 && n <= 290, 1'b1, "parked time wrong")
    expect_rd(8'h8F, 8'h74);
  endtask

  // trim moves the fast rate linearly; top bits stay clear
  task t_trim;
    int c;
    rises(2000, 1'b0, c);
    `IOS_CHK(c >= 63 && c <= 65, 1'b1, "fast rate")
    wr(8'h90, 8'h1F);
    expect_rd(8'h90, 8'h1F);
    repeat (10) @(posedge CLK_SYS);
    rises(2000, 1'b0, c);
    `IOS_CHK(c >= 69 && c <= 74, 1'b1, "upper trim rate")
    wr(8'h90, 8'h20);
    repeat (10) @(posedge CLK_SYS);
    rises(2000, 1'b0, c);
    `IOS_CHK(c >= 54 && c <= 58, 1'b1, "lower trim rate")
    wr(8'h90, 8'hC0);
    expect_rd(8'h90, 8'h00);
  endtask

  // every postscaler code, fast to fast, flag stays set
  task t_rates;
    int c;
    int prev;
    prev = 7;
    for (int s = 6; s >= 1; s--) begin
      wr(8'h8F, {1'b0, 3'(s), 4'h0});
      repeat ((125 << (7 - prev)) / 4 + 9 * (125 << (7 - s)) / 4 + 8) @(posedge CLK_SYS);
      rises(125 << (7 - s), 1'b0, c);
      `IOS_CHK(c >= 3 && c <= 5, 1'b1, "postscaler rate")
      expect_rd(8'h8F, {1'b0, 3'(s), 4'h4});
      prev = s;
    end
  endtask

  // slow source keeps running for the watchdog and the power-up timer
  task t_slow_keep;
    int c;
    WDT_EN <= 1'b1;
    rises(8100, 1'b1, c);
    `IOS_CHK(c >= 1, 1'b1, "slow stopped with watchdog")
    WDT_EN <= 1'b0;
    PWRT_EN <= 1'b1;
    rises(8100, 1'b1, c);
    `IOS_CHK(c >= 1, 1'b1, "slow stopped with timer")
  endtask

  // all-io mode: port bits reach the pins, pin levels come back one cycle later
  task t_pins;
    logic i7;
    logic i6;
    @(posedge CLK_SYS);
    OSC_MODE <= 3'h5;
    repeat (2) @(posedge CLK_SYS);
    i7 = IN_I;
    i6 = OUT_I;
    repeat (16) begin
      @(posedge CLK_SYS);
      `IOS_CHK({IN_O, OUT_O}, {B7_O, B6_O}, "port bits to pins")
      `IOS_CHK({B7_I, B6_I}, {i7, i6}, "pins to port bits")
      i7 = IN_I;
      i6 = OUT_I;
    end
    OSC_MODE <= 3'h4;
  endtask

  // back through the slow code and out again: flag clears, then sets after the count
  task t_flag;
    wr(8'h8F, 8'h00);
    wr(8'h8F, 8'h70);
    expect_rd(8'h8F, 8'h70);
    repeat (SETTLE) @(posedge CLK_SYS);
    expect_rd(8'h8F, 8'h74);
  endtask

  initial begin
    repeat (8) @(posedge CLK_SYS);
    RST <= 1'b0;
    expect_rd(8'h8F, 8'h00);
    expect_rd(8'h90, 8'h00);
    expect_rd(8'h55, 8'h00);
    t_modes();
    t_pins();
    t_leave_slow();
    t_trim();
    t_rates();
    t_flag();
    t_slow_keep();
    close_out();
  end
endmodule
